// file: verilog/eim_defs.svh
`ifndef EIM_DEFS_SVH
`define EIM_DEFS_SVH
`define EIM_REG_W       16
`define EIM_ADDR_W      8
`define EIM_OFS_ENABLE  8'h90
`define EIM_OFS_FLAGS   8'h92
`define EIM_ENABLE_RST  16'h0000
`define EIM_FLAGS_RST   16'h0300
`define EIM_RSVD_MASK   16'h1480
`define EIM_W1C_MASK    16'hEB40
`define EIM_BIT_ENERGY  2
`define EIM_BIT_DELAYED 0
`define EIM_DELAY_PAIR  16'h0005
`endif

// file: verilog/eim_pkg.sv
`default_nettype none
package eim_pkg;
  typedef logic [15:0] eim_word_t;
  typedef enum logic [1:0]
  {
    EIM_WAKE_NONE    = 2'b00,
    EIM_WAKE_ENERGY  = 2'b01,
    EIM_WAKE_DELAYED = 2'b10
  } eim_wake_kind_t;
endpackage : eim_pkg
`default_nettype wire

// file: verilog/eim_flag_bit.sv
`timescale 1ns/1ps
`default_nettype none
module eim_flag_bit
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic rst_val,
  input  wire logic set_i,
  input  wire logic clr_i,
  output var  logic flag_o
);
  logic flag_d;
  logic flag_q;

  // Event wins over a clear in the same cycle; inverted cells see it on clr_i
  always_comb
  begin
    flag_d = flag_q;
    if (rst_val)
    begin
      if (set_i)
        flag_d = 1'b1;
      if (clr_i)
        flag_d = 1'b0;
    end
    else
    begin
      if (clr_i)
        flag_d = 1'b0;
      if (set_i)
        flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  // Reset value applied here by XOR of the stored bit with rst_val
  assign flag_o = flag_q ^ rst_val;
endmodule : eim_flag_bit
`default_nettype wire

// file: verilog/eim_irq_enable.sv
`timescale 1ns/1ps
`default_nettype none
`include "eim_defs.svh"
module eim_irq_enable
(
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic [`EIM_ADDR_W-1:0] reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire eim_pkg::eim_word_t     reg_wdata,
  output var  eim_pkg::eim_word_t     reg_rdata,
  input  wire eim_pkg::eim_word_t     event_set,
  input  wire logic [3:0]             wake_clr,
  input  wire logic                   host_ready,
  output var  eim_pkg::eim_wake_kind_t energy_kind,
  output var  eim_pkg::eim_word_t     enable_out,
  output var  logic                   irq_out
);
  import eim_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  eim_word_t en_d;
  eim_word_t en_q;
  eim_word_t flags;
  eim_word_t clr_vec;
  eim_word_t set_vec;
  eim_word_t rst_vec;
  eim_word_t rdata_d;
  eim_wake_kind_t kind_d;
  logic      irq_d;
  logic      en_wr;
  logic      fl_wr;

  assign en_wr   = reg_wr && (reg_addr == `EIM_OFS_ENABLE);
  assign fl_wr   = reg_wr && (reg_addr == `EIM_OFS_FLAGS);
  assign rst_vec = `EIM_FLAGS_RST;

  // All bits writable, reserved ones stored too
  always_comb
  begin
    en_d = en_q;
    if (en_wr)
      en_d = reg_wdata;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      en_q <= `EIM_ENABLE_RST;
    else
      en_q <= en_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake flags clear only via the power manager strobes, not by W1C
  always_comb
  begin
    clr_vec = fl_wr ? (reg_wdata & `EIM_W1C_MASK) : '0;
    clr_vec[5:2] = clr_vec[5:2] | {wake_clr[3], wake_clr[2], wake_clr[1], wake_clr[0]};
    // Energy event always logged, only the pin waits for host access
    set_vec = event_set & ~`EIM_RSVD_MASK;
  end

  genvar gi;
  generate
    for (gi = 0; gi < `EIM_REG_W; gi++)
    begin : g_flag
      // Stored inverted where reset value is one, so the cell resets to zero
      eim_flag_bit u_flag
      (
        .clk    (clk),
        .arst_n (arst_n),
        .rst_val(rst_vec[gi]),
        .set_i  (rst_vec[gi] ? clr_vec[gi] : set_vec[gi]),
        .clr_i  (rst_vec[gi] ? set_vec[gi] : clr_vec[gi]),
        .flag_o (flags[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  logic irq_q;
  eim_word_t rdata_q;
  eim_wake_kind_t kind_q;

  always_comb
  begin
    // Enable masks the pin and energy_kind; flags are untouched
    irq_d = |(flags & en_q & ~`EIM_RSVD_MASK);
    if (en_q[`EIM_BIT_DELAYED] && !host_ready)
      irq_d = |(flags & en_q & ~`EIM_RSVD_MASK & ~`EIM_DELAY_PAIR);
    kind_d = EIM_WAKE_NONE;
    if (flags[`EIM_BIT_ENERGY] && en_q[`EIM_BIT_ENERGY])
      kind_d = en_q[`EIM_BIT_DELAYED] ? EIM_WAKE_DELAYED : EIM_WAKE_ENERGY;
    rdata_d = '0;
    if (reg_rd && reg_addr == `EIM_OFS_ENABLE)
      rdata_d = en_q;
    else if (reg_rd && reg_addr == `EIM_OFS_FLAGS)
      rdata_d = flags;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_q   <= 1'b0;
      rdata_q <= '0;
      kind_q  <= EIM_WAKE_NONE;
    end
    else
    begin
      irq_q   <= irq_d;
      rdata_q <= rdata_d;
      kind_q  <= kind_d;
    end
  end

  assign irq_out     = irq_q;
  assign reg_rdata   = rdata_q;
  assign energy_kind = kind_q;
  assign enable_out  = en_q;

  ////////////////////////////////////////////////////////////////////////
  property p_irq_follow;
    @(posedge clk) disable iff (!arst_n)
    (|(flags & en_q & ~`EIM_RSVD_MASK & ~`EIM_DELAY_PAIR)) |=> irq_out;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq missing");

  property p_irq_quiet;
    @(posedge clk) disable iff (!arst_n)
    (en_q == 16'h0000) |=> !irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq while masked");

  property p_en_write;
    @(posedge clk) disable iff (!arst_n)
    en_wr |=> (en_q == $past(reg_wdata));
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable not stored");

  property p_mask_keeps_flags;
    @(posedge clk) disable iff (!arst_n)
    (en_wr && !fl_wr && wake_clr == 4'h0) |=> (flags & $past(flags)) == $past(flags);
  endproperty
  a_mask_keeps_flags: assert property (p_mask_keeps_flags) else $error("flag lost");

  property p_set_wins;
    @(posedge clk) disable iff (!arst_n)
    (fl_wr && reg_wdata[15] && event_set[15]) |=> flags[15];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

  property p_w1c;
    @(posedge clk) disable iff (!arst_n)
    (fl_wr && reg_wdata[13] && !event_set[13]) |=> !flags[13];
  endproperty
  a_w1c: assert property (p_w1c) else $error("w1c failed");

  property p_delay_hold;
    @(posedge clk) disable iff (!arst_n)
    (en_q == `EIM_DELAY_PAIR && !host_ready) |=> !irq_out;
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("delayed irq early");

  property p_kind;
    @(posedge clk) disable iff (!arst_n)
    (flags[2] && en_q[2] && en_q[0]) |=> (energy_kind == EIM_WAKE_DELAYED);
  endproperty
  a_kind: assert property (p_kind) else $error("energy kind wrong");

  property p_kind_energy;
    @(posedge clk) disable iff (!arst_n)
    (flags[`EIM_BIT_ENERGY] && en_q[`EIM_BIT_ENERGY] && !en_q[`EIM_BIT_DELAYED])
      |=> (energy_kind == EIM_WAKE_ENERGY);
  endproperty
  a_kind_energy: assert property (p_kind_energy) else $error("plain energy kind wrong");

  property p_delay_release;
    @(posedge clk) disable iff (!arst_n)
    (flags[`EIM_BIT_ENERGY] && en_q[`EIM_BIT_ENERGY] && en_q[`EIM_BIT_DELAYED] && host_ready)
      |=> irq_out;
  endproperty
  a_delay_release: assert property (p_delay_release) else $error("delayed irq lost");

  property p_flag_set;
    @(posedge clk) disable iff (!arst_n)
    event_set[15] |=> flags[15];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event not logged");

  property p_wake_keep;
    @(posedge clk) disable iff (!arst_n)
    (fl_wr && flags[5] && !wake_clr[3]) |=> flags[5];
  endproperty
  a_wake_keep: assert property (p_wake_keep) else $error("wake flag cleared by write");

  property p_rsvd_silent;
    @(posedge clk) disable iff (!arst_n)
    (flags & `EIM_RSVD_MASK) == '0;
  endproperty
  a_rsvd_silent: assert property (p_rsvd_silent) else $error("reserved flag set");

  property p_read_enable;
    @(posedge clk) disable iff (!arst_n)
    (reg_rd && reg_addr == `EIM_OFS_ENABLE) |=> (reg_rdata == $past(en_q));
  endproperty
  a_read_enable: assert property (p_read_enable) else $error("enable readback wrong");

  property p_read_keeps;
    @(posedge clk) disable iff (!arst_n)
    (reg_rd && !fl_wr && wake_clr == 4'h0) |=> (flags & $past(flags)) == $past(flags);
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read cleared a flag");

  ////////////////////////////////////////////////////////////////////////
  // Main scenarios
  c_irq: cover property (@(posedge clk) disable iff (!arst_n) $rose(irq_out));
  c_race: cover property (@(posedge clk) disable iff (!arst_n)
    fl_wr && reg_wdata[15] && event_set[15]);
  c_kind_energy: cover property (@(posedge clk) disable iff (!arst_n)
    energy_kind == EIM_WAKE_ENERGY);
  c_delay: cover property (@(posedge clk) disable iff (!arst_n)
    en_q[0] && flags[2] && $rose(host_ready));
  c_clear: cover property (@(posedge clk) disable iff (!arst_n) fl_wr ##1 !irq_out);
endmodule : eim_irq_enable
`default_nettype wire

// file: verification/eim_irq_enable_bench.sv
`timescale 1ns/1ps
`default_nettype none
module eim_irq_enable_bench;
  import eim_pkg::*;
  logic           clk = 1'b0;
  logic           arst_n = 1'b0;
  logic [7:0]     reg_addr = 8'h00;
  logic           reg_wr = 1'b0;
  logic           reg_rd = 1'b0;
  eim_word_t      reg_wdata = 16'h0000;
  eim_word_t      reg_rdata;
  eim_word_t      event_set = 16'h0000;
  logic [3:0]     wake_clr = 4'h0;
  logic           host_ready = 1'b0;
  eim_wake_kind_t energy_kind;
  eim_word_t      enable_out;
  logic           irq_out;
  eim_word_t      rv;
  int             n_fail = 0;
  int             checks = 0;
  int             cyc = 0;
  always #2 clk = ~clk;
  eim_irq_enable i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .event_set(event_set), .wake_clr(wake_clr), .host_ready(host_ready),
    .energy_kind(energy_kind), .enable_out(enable_out), .irq_out(irq_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Idle cycle after each strobe so back-to-back calls never retoggle it
  task automatic wr(input logic [7:0] a, input eim_word_t d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk) reg_wr = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk) reg_rd = 1'b0;
    rv = reg_rdata;
    @(negedge clk);
  endtask : rd
  task automatic ev(input eim_word_t m);
    event_set = m;
    @(negedge clk) event_set = 16'h0000;
    repeat (2) @(negedge clk);
  endtask : ev
  task automatic clr_all;
    wr(8'h92, 16'hFFFF);
    wake_clr = 4'hF;
    @(negedge clk) wake_clr = 4'h0;
  endtask : clr_all
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(8'h90);
    chk("enable_rst", 16'h0000, rv);
    rd(8'h92);
    chk("flags_rst", 16'h0300, rv);
    chk("irq_rst", 16'h0000, {15'h0, irq_out});
  endtask : t_reset
  // Event and write-one-clear in one cycle, on a plain and an inverted cell
  task automatic t_race;
    clr_all();
    reg_addr = 8'h92;
    reg_wdata = 16'h8200;
    event_set = 16'h8200;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    event_set = 16'h0000;
    @(negedge clk);
    rd(8'h92);
    chk("set_wins", 16'h8200, rv & 16'h8200);
  endtask : t_race
  task automatic t_gate;
    int bl[11] = '{15, 14, 13, 11, 9, 8, 6, 5, 4, 3, 2};
    eim_word_t m;
    foreach (bl[i])
    begin
      m = 16'h0001 << bl[i];
      wr(8'h90, 16'h0000);
      clr_all();
      ev(m);
      chk("irq_masked", 16'h0000, {15'h0, irq_out});
      wr(8'h90, m);
      chk("enable_out", m, enable_out);
      chk("irq_on", 16'h0001, {15'h0, irq_out});
      wr(8'h90, 16'h0000);
      chk("irq_off", 16'h0000, {15'h0, irq_out});
      rd(8'h92);
      chk("flag_kept", m, rv & m);
      // Wake flags ignore write-one, only their own strobe clears them
      if (bl[i] < 6)
      begin
        wr(8'h92, m);
        rd(8'h92);
        chk("wake_keep", m, rv & m);
        wake_clr = 4'h1 << (bl[i] - 2);
        @(negedge clk) wake_clr = 4'h0;
      end
      else
        wr(8'h92, m);
      rd(8'h92);
      chk("flag_clr", 16'h0000, rv & m);
    end
  endtask : t_gate
  task automatic t_energy;
    clr_all();
    wr(8'h90, 16'h0005);
    ev(16'h0004);
    chk("irq_held", 16'h0000, {15'h0, irq_out});
    rd(8'h92);
    chk("energy_logged", 16'h0004, rv & 16'h0004);
    host_ready = 1'b1;
    repeat (2) @(negedge clk);
    chk("irq_release", 16'h0001, {15'h0, irq_out});
    ev(16'h0004);
    chk("irq_delay", 16'h0001, {15'h0, irq_out});
    chk("kind_delay", {14'h0, EIM_WAKE_DELAYED}, {14'h0, energy_kind});
    wr(8'h90, 16'h0004);
    chk("kind_energy", {14'h0, EIM_WAKE_ENERGY}, {14'h0, energy_kind});
    wr(8'h90, 16'h0002);
    chk("kind_none", {14'h0, EIM_WAKE_NONE}, {14'h0, energy_kind});
    ev(16'h0002);
    chk("irq_bus_err", 16'h0001, {15'h0, irq_out});
  endtask : t_energy
  task automatic t_rsvd;
    wr(8'h90, 16'h0000);
    clr_all();
    wr(8'h90, 16'h1480);
    ev(16'h1480);
    chk("irq_rsvd", 16'h0000, {15'h0, irq_out});
    wr(8'h94, 16'hFFFF);
    rd(8'h94);
    chk("unmapped", 16'h0000, rv);
    rd(8'h90);
    chk("rsvd_store", 16'h1480, rv);
  endtask : t_rsvd
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      test_done();
    end
  end
  initial
  begin
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_race();
    t_gate();
    t_rsvd();
    t_energy();
    test_done();
  end
endmodule : eim_irq_enable_bench
`default_nettype wire
